//--- rtl/mtk_device.sv
// Minute timekeeper: always-on quarter-second counter with its two SFRs
`timescale 1ns/1ps
`include "mtk_map.svh"

module mtk_device #(
  parameter int unsigned TICK_DIV = `MTK_CLK_HZ / `MTK_TICK_HZ
) (
  input wire logic clk_sys, // System clock, 125 MHz
  input wire logic arst_n, // Primary reset, async, active low
  mtk_sfr_if.device sfr, // SFR link to the controller
  input wire logic supplyStablePin, // Converter sustains processor supply
  input wire logic converterActivePin, // Converter is running
  output logic converterStart, // Request to start converter and power up
  output logic quarterTick, // One-cycle pulse at each 4 Hz tick
  output logic [7:0] quarterCount // Live always-on count
);

  localparam logic [`MTK_DIV_WIDTH-1:0] DivLast = `MTK_DIV_WIDTH'(TICK_DIV - 1);

  function automatic logic [7:0] nextCount(input logic [7:0] cur);
    nextCount = (cur == `MTK_TERMINAL_COUNT) ? 8'h00 : 8'(cur + 8'h01);
  endfunction

  // Write decode for one SFR address
  function automatic logic sfrHit(input logic en, input logic [7:0] addr,
                                  input logic [7:0] want);
    sfrHit = en && (addr == want);
  endfunction

  // Bit 7 reads the true latch, so a read-modify-write of control is unsafe
  function automatic logic [7:0] ctrlImage(input logic minBit, input logic holdBit,
                                           input logic loadBit, input logic strobeBit);
    ctrlImage = {minBit, 4'h0, holdBit, loadBit, strobeBit};
  endfunction

  logic [`MTK_DIV_WIDTH-1:0] div_reg;
  logic stableMeta_reg;
  logic stable_reg;
  logic activeMeta_reg;
  logic active_reg;
  logic trueMin_reg;
  logic ctrlMin_reg;
  logic ctrlHold_reg;
  logic ctrlLoad_reg;
  logic ctrlStrobe_reg;
  logic [7:0] countSfr_reg;
  logic loadPending_reg;
  logic [7:0] loadValue_reg;
  logic [7:0] rdData_reg;
  logic [7:0] count_next;
  logic ctrlWrite;
  logic countWrite;
  logic strobeEdge;
  logic minuteEvent;

  assign ctrlWrite = sfrHit(sfr.sfrWrEn, sfr.sfrAddr, `MTK_CONTROL_ADDR);
  assign countWrite = sfrHit(sfr.sfrWrEn, sfr.sfrAddr, `MTK_COUNT_ADDR);
  // Only a low-to-high transition of the strobe bit hands values across
  assign strobeEdge = ctrlWrite && sfr.sfrWrData[`MTK_CTRL_STROBE_BIT] && !ctrlStrobe_reg;
  // A load lands at the next tick, so the live count keeps the old time until that tick
  assign count_next = loadPending_reg ? loadValue_reg : nextCount(quarterCount);
  assign minuteEvent = quarterTick && (count_next == `MTK_TERMINAL_COUNT);

  // Tick divider; the always-on side only moves on this enable
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      div_reg <= '0;
      quarterTick <= 1'b0;
    end else if (div_reg == DivLast) begin
      div_reg <= '0;
      quarterTick <= 1'b1;
    end else begin
      div_reg <= div_reg + 1'b1;
      quarterTick <= 1'b0;
    end
  end

  // Supply status arrives from the analogue side
  // Two flops per pin; a level shorter than one clock may be missed
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      stableMeta_reg <= 1'b0;
      stable_reg <= 1'b0;
      activeMeta_reg <= 1'b0;
      active_reg <= 1'b0;
    end else begin
      stableMeta_reg <= supplyStablePin;
      stable_reg <= stableMeta_reg;
      activeMeta_reg <= converterActivePin;
      active_reg <= activeMeta_reg;
    end
  end

  // Always-on counter; reset only by the primary reset, not by supply state
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      quarterCount <= `MTK_COUNT_RESET;
    end else if (quarterTick) begin
      quarterCount <= count_next;
    end
  end

  // Load request captured at the strobe edge, applied at the next tick
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      loadPending_reg <= 1'b0;
      loadValue_reg <= `MTK_COUNT_RESET;
    end else if (strobeEdge && ctrlLoad_reg) begin
      loadPending_reg <= 1'b1;
      loadValue_reg <= countSfr_reg;
    end else if (quarterTick) begin
      loadPending_reg <= 1'b0;
    end
  end

  // True minute latch; a tick event wins over a clearing strobe
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      trueMin_reg <= 1'b0;
    end else if (minuteEvent) begin
      trueMin_reg <= 1'b1;
    end else if (strobeEdge) begin
      trueMin_reg <= ctrlMin_reg;
    end
  end

  // Control SFR; the write-hold bit also clears itself once a load lands
  // A hold written without a load stays set until software clears it
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ctrlMin_reg <= 1'b0;
      ctrlHold_reg <= 1'b0;
      ctrlLoad_reg <= 1'b0;
      ctrlStrobe_reg <= 1'b0;
    end else begin
      if (ctrlWrite) begin
        ctrlMin_reg <= sfr.sfrWrData[`MTK_CTRL_MIN_BIT];
        ctrlLoad_reg <= sfr.sfrWrData[`MTK_CTRL_LOAD_BIT];
        ctrlStrobe_reg <= sfr.sfrWrData[`MTK_CTRL_STROBE_BIT];
      end
      if (ctrlWrite) begin
        ctrlHold_reg <= sfr.sfrWrData[`MTK_CTRL_HOLD_BIT];
      end else if (quarterTick && loadPending_reg) begin
        ctrlHold_reg <= 1'b0;
      end
    end
  end

  // Count SFR; software write wins over a refresh in the same cycle
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      countSfr_reg <= `MTK_COUNT_RESET;
    end else if (countWrite) begin
      countSfr_reg <= sfr.sfrWrData;
    end else if (quarterTick && stable_reg && !ctrlHold_reg) begin
      countSfr_reg <= count_next;
    end
  end

  // Converter start request held until the converter reports running
  // No timeout: a converter that never reports running leaves the request up
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      converterStart <= 1'b0;
    end else if (minuteEvent && !active_reg) begin
      converterStart <= 1'b1;
    end else if (active_reg) begin
      converterStart <= 1'b0;
    end
  end

  // Reads show the true flag, not the written copy
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rdData_reg <= 8'h00;
    end else begin
      case (sfr.sfrAddr)
        `MTK_CONTROL_ADDR: rdData_reg <= ctrlImage(trueMin_reg, ctrlHold_reg, ctrlLoad_reg,
                                                   ctrlStrobe_reg);
        `MTK_COUNT_ADDR: rdData_reg <= countSfr_reg;
        default: rdData_reg <= 8'h00;
      endcase
    end
  end

  assign sfr.sfrRdData = rdData_reg;
  assign sfr.minuteIrq = trueMin_reg;

endmodule

//--- rtl/mtk_map.svh
// Constants for the minute timekeeper: offsets, fields, reset values and timing
`ifndef MTK_MAP_SVH
`define MTK_MAP_SVH

`define MTK_CONTROL_ADDR 8'hcd
`define MTK_COUNT_ADDR 8'hce

`define MTK_CTRL_MIN_BIT 7
`define MTK_CTRL_HOLD_BIT 2
`define MTK_CTRL_LOAD_BIT 1
`define MTK_CTRL_STROBE_BIT 0

`define MTK_TERMINAL_COUNT 8'hef
`define MTK_COUNT_RESET 8'h00
`define MTK_CTRL_RESET 8'h00

`define MTK_CLK_HZ 125000000
`define MTK_TICK_HZ 4
`define MTK_DIV_WIDTH 25

`define MTK_HOST_CMD_OFFSET 12'h000
`define MTK_HOST_STATUS_OFFSET 12'h004
`define MTK_HOST_IRQ_STATUS_OFFSET 12'h008
`define MTK_HOST_IRQ_MASK_OFFSET 12'h00c

`define MTK_CMD_DATA_LSB 0
`define MTK_CMD_ADDR_LSB 8
`define MTK_CMD_WRITE_BIT 16
`define MTK_CMD_START_BIT 17
`define MTK_STAT_BUSY_BIT 0
`define MTK_STAT_RDATA_LSB 8
`define MTK_IRQ_MINUTE_BIT 0
`define MTK_IRQ_DONE_BIT 1
`define MTK_IRQ_WIDTH 2

`endif

//--- rtl/mtk_pkg.sv
// Types used by the controller end of the minute timekeeper
package mtk_pkg;
  typedef enum logic [1:0] {
    MTK_IDLE = 2'b00,
    MTK_ISSUE = 2'b01,
    MTK_WAIT = 2'b11,
    MTK_DONE = 2'b10
  } mtk_access_state_type;
endpackage

//--- rtl/mtk_sfr_if.sv
// Special function register link between controller and timekeeper
`timescale 1ns/1ps
interface mtk_sfr_if;
  logic [7:0] sfrAddr;
  logic [7:0] sfrWrData;
  logic sfrWrEn;
  logic [7:0] sfrRdData;
  logic minuteIrq;

  modport host (
    output sfrAddr,
    output sfrWrData,
    output sfrWrEn,
    input sfrRdData,
    input minuteIrq
  );

  modport device (
    input sfrAddr,
    input sfrWrData,
    input sfrWrEn,
    output sfrRdData,
    output minuteIrq
  );
endinterface

//--- rtl/mtk_host.sv
// Controller end: APB registers that drive SFR accesses to the timekeeper
`timescale 1ns/1ps
`include "mtk_map.svh"

module mtk_host (
  input wire logic clk_sys, // System clock, 125 MHz
  input wire logic arst_n, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction, high for write
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  output logic irqOut, // Level interrupt
  mtk_sfr_if.host sfr // SFR link to the timekeeper
);

  mtk_pkg::mtk_access_state_type state_reg;
  logic [7:0] cmdAddr_reg;
  logic [7:0] cmdData_reg;
  logic cmdWrite_reg;
  logic [7:0] rdData_reg;
  logic [7:0] sfrAddr_reg;
  logic [7:0] sfrWrData_reg;
  logic sfrWrEn_reg;
  logic minPrev_reg;
  logic [`MTK_IRQ_WIDTH-1:0] irqStatus_reg;
  logic [`MTK_IRQ_WIDTH-1:0] irqMask_reg;
  logic accessStart;
  logic accessEnd;
  logic busy;
  logic startCmd;
  logic [`MTK_IRQ_WIDTH-1:0] irqSet;

  assign accessStart = psel && penable && !pready;
  assign accessEnd = psel && penable && pready;
  assign busy = (state_reg != mtk_pkg::MTK_IDLE);
  // Commands pass one by one; a start written while busy is dropped, not queued
  assign startCmd = accessEnd && pwrite && (paddr == `MTK_HOST_CMD_OFFSET)
                    && pwdata[`MTK_CMD_START_BIT] && !busy;
  assign irqSet[`MTK_IRQ_MINUTE_BIT] = sfr.minuteIrq && !minPrev_reg;
  assign irqSet[`MTK_IRQ_DONE_BIT] = (state_reg == mtk_pkg::MTK_DONE);

  // One wait state on every APB transfer
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= accessStart;
      if (accessStart) begin
        pslverr <= 1'b0;
        case (paddr)
          `MTK_HOST_CMD_OFFSET: prdata <= {15'h0000, cmdWrite_reg, cmdAddr_reg, cmdData_reg};
          `MTK_HOST_STATUS_OFFSET: prdata <= {16'h0000, rdData_reg, 7'h00, busy};
          `MTK_HOST_IRQ_STATUS_OFFSET: prdata <= {30'h0000_0000, irqStatus_reg};
          `MTK_HOST_IRQ_MASK_OFFSET: prdata <= {30'h0000_0000, irqMask_reg};
          default: begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

  // Command latch; a start while busy is dropped
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cmdAddr_reg <= 8'h00;
      cmdData_reg <= 8'h00;
      cmdWrite_reg <= 1'b0;
    end else if (accessEnd && pwrite && (paddr == `MTK_HOST_CMD_OFFSET) && !busy) begin
      cmdData_reg <= pwdata[`MTK_CMD_DATA_LSB +: 8];
      cmdAddr_reg <= pwdata[`MTK_CMD_ADDR_LSB +: 8];
      cmdWrite_reg <= pwdata[`MTK_CMD_WRITE_BIT];
    end
  end

  // SFR access sequencer: drive, let the device register its answer, capture
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= mtk_pkg::MTK_IDLE;
      sfrAddr_reg <= 8'h00;
      sfrWrData_reg <= 8'h00;
      sfrWrEn_reg <= 1'b0;
      rdData_reg <= 8'h00;
    end else begin
      case (state_reg)
        mtk_pkg::MTK_IDLE: begin
          if (startCmd) begin
            sfrAddr_reg <= pwdata[`MTK_CMD_ADDR_LSB +: 8];
            sfrWrData_reg <= pwdata[`MTK_CMD_DATA_LSB +: 8];
            sfrWrEn_reg <= pwdata[`MTK_CMD_WRITE_BIT];
            state_reg <= mtk_pkg::MTK_ISSUE;
          end
        end
        mtk_pkg::MTK_ISSUE: begin
          sfrWrEn_reg <= 1'b0;
          state_reg <= mtk_pkg::MTK_WAIT;
        end
        mtk_pkg::MTK_WAIT: begin
          rdData_reg <= sfr.sfrRdData;
          state_reg <= mtk_pkg::MTK_DONE;
        end
        mtk_pkg::MTK_DONE: state_reg <= mtk_pkg::MTK_IDLE;
        default: state_reg <= mtk_pkg::MTK_IDLE;
      endcase
    end
  end

  // Sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      minPrev_reg <= 1'b0;
      irqStatus_reg <= '0;
      irqMask_reg <= '0;
      irqOut <= 1'b0;
    end else begin
      minPrev_reg <= sfr.minuteIrq;
      if (accessEnd && pwrite && (paddr == `MTK_HOST_IRQ_STATUS_OFFSET)) begin
        irqStatus_reg <= (irqStatus_reg & ~pwdata[`MTK_IRQ_WIDTH-1:0]) | irqSet;
      end else begin
        irqStatus_reg <= irqStatus_reg | irqSet;
      end
      if (accessEnd && pwrite && (paddr == `MTK_HOST_IRQ_MASK_OFFSET)) begin
        irqMask_reg <= pwdata[`MTK_IRQ_WIDTH-1:0];
      end
      irqOut <= |(irqStatus_reg & irqMask_reg);
    end
  end

  assign sfr.sfrAddr = sfrAddr_reg;
  assign sfr.sfrWrData = sfrWrData_reg;
  assign sfr.sfrWrEn = sfrWrEn_reg;

endmodule

//--- test/mtk_props.sv
// Concurrent checks on the link between controller and timekeeper
`timescale 1ns/1ps
module mtk_props (
  input wire logic clk_sys, // System clock
  input wire logic arst_n, // Primary reset, active low
  input wire logic [7:0] sfrAddr, // SFR address
  input wire logic [7:0] sfrWrData, // SFR write byte
  input wire logic sfrWrEn, // SFR write strobe
  input wire logic [7:0] sfrRdData, // SFR read byte
  input wire logic minuteIrq, // True minute latch
  input wire logic quarterTick, // Tick pulse
  input wire logic [7:0] quarterCount // Live count
);
  logic [7:0] ctrlHeld_reg;
  logic tickSeen_reg;
  logic loadPend_reg;
  logic [7:0] countSfr_reg;
  logic [7:0] loadVal_reg;
  logic strobeEdge;
  logic minuteEvt;
  // The strobe edge acts on the control bits stored by earlier writes
  assign strobeEdge = sfrWrEn && sfrAddr == 8'hcd && sfrWrData[0] && !ctrlHeld_reg[0];
  // The counter has just taken the value 239
  assign minuteEvt = tickSeen_reg && quarterCount == 8'hef;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ctrlHeld_reg <= 8'h00;
      tickSeen_reg <= 1'b0;
    end else begin
      tickSeen_reg <= quarterTick;
      if (sfrWrEn && sfrAddr == 8'hcd) begin
        ctrlHeld_reg <= sfrWrData;
      end
    end
  end
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      countSfr_reg <= 8'h00;
    end else if (sfrWrEn && sfrAddr == 8'hce) begin
      countSfr_reg <= sfrWrData;
    end
  end
  // Pending load is dropped at the same edge at which its tick applies it
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      loadPend_reg <= 1'b0;
      loadVal_reg <= 8'h00;
    end else if (strobeEdge && ctrlHeld_reg[1]) begin
      loadPend_reg <= 1'b1;
      loadVal_reg <= countSfr_reg;
    end else if (quarterTick) begin
      loadPend_reg <= 1'b0;
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  sequence s_strobe_set;
    strobeEdge && ctrlHeld_reg[7];
  endsequence
  sequence s_strobe_clr;
    strobeEdge && !ctrlHeld_reg[7];
  endsequence
  sequence s_ctrl_read;
    sfrAddr == 8'hcd ##1 $stable(minuteIrq);
  endsequence
  // The counter takes its new value at the tick edge, seen one edge later
  property p_count_still;
    !quarterTick |=> $stable(quarterCount);
  endproperty
  property p_count_step;
    quarterTick && !loadPend_reg && quarterCount != 8'hef
      |=> quarterCount == $past(quarterCount) + 8'h01;
  endproperty
  property p_wrap;
    quarterTick && !loadPend_reg && quarterCount == 8'hef |=> quarterCount == 8'h00;
  endproperty
  property p_load;
    quarterTick && loadPend_reg |=> quarterCount == $past(loadVal_reg);
  endproperty
  property p_min_set;
    minuteEvt |-> minuteIrq;
  endproperty
  property p_min_cause;
    $rose(minuteIrq) |-> minuteEvt || $past(strobeEdge && ctrlHeld_reg[7]);
  endproperty
  property p_flag_set;
    s_strobe_set |=> minuteIrq;
  endproperty
  property p_flag_clr;
    s_strobe_clr |=> minuteIrq == minuteEvt;
  endproperty
  property p_irq_hold;
    minuteIrq && !strobeEdge |=> minuteIrq;
  endproperty
  property p_rd_min;
    s_ctrl_read |-> sfrRdData[7] == minuteIrq;
  endproperty
  property p_rd_unmapped;
    sfrAddr != 8'hcd && sfrAddr != 8'hce |=> sfrRdData == 8'h00;
  endproperty
  a_count_still: assert property (p_count_still)
    else $error("count moved without a tick");
  a_count_step: assert property (p_count_step)
    else $error("count did not step by one");
  a_wrap: assert property (p_wrap)
    else $error("count did not wrap to zero");
  a_load: assert property (p_load)
    else $error("load value not applied at tick");
  a_min_set: assert property (p_min_set)
    else $error("minute flag missing at terminal count");
  a_min_cause: assert property (p_min_cause)
    else $error("minute flag rose without cause");
  a_flag_set: assert property (p_flag_set)
    else $error("strobe did not copy set flag");
  a_flag_clr: assert property (p_flag_clr)
    else $error("strobe did not copy cleared flag");
  a_irq_hold: assert property (p_irq_hold)
    else $error("minute flag dropped without strobe");
  a_rd_min: assert property (p_rd_min)
    else $error("control read shows wrong minute latch");
  a_rd_unmapped: assert property (p_rd_unmapped)
    else $error("unmapped SFR read not zero");
endmodule

//--- test/minute_timekeeper_bench.sv
// Self-checking bench: controller and timekeeper joined by their SFR link
`timescale 1ns/1ps
`include "mtk_map.svh"
module minute_timekeeper_bench;
  localparam int TickDiv = 64;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic supplyStablePin = 1'b1;
  logic converterActivePin = 1'b1;
  logic [31:0] prdata;
  logic pready, pslverr, irqOut, converterStart, quarterTick;
  logic [7:0] quarterCount;
  logic [31:0] rd;
  int failures = 0;
  int samplesChecked = 0;
  int cycles = 0;
  int seed = 32'h9521;
  int modelCount, loadValue, sinceTick;
  bit loadPending, ctrlStrobe, ctrlLoad, checkCount;
  mtk_sfr_if sfrLink ();
  mtk_host u_mtk_host (.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irqOut(irqOut), .sfr(sfrLink.host));
  mtk_device #(.TICK_DIV(TickDiv)) u_mtk_device (.clk_sys(clk_sys), .arst_n(arst_n),
    .sfr(sfrLink.device), .supplyStablePin(supplyStablePin),
    .converterActivePin(converterActivePin), .converterStart(converterStart),
    .quarterTick(quarterTick), .quarterCount(quarterCount));
  mtk_props u_mtk_props (.clk_sys(clk_sys), .arst_n(arst_n), .sfrAddr(sfrLink.sfrAddr),
    .sfrWrData(sfrLink.sfrWrData), .sfrWrEn(sfrLink.sfrWrEn), .sfrRdData(sfrLink.sfrRdData),
    .minuteIrq(sfrLink.minuteIrq), .quarterTick(quarterTick), .quarterCount(quarterCount));
  always #4 clk_sys = ~clk_sys;
  task automatic finishTest();
    $display("checks %0d mismatches %0d", samplesChecked, failures);
    if (failures == 0 && samplesChecked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      failures++;
      finishTest();
    end
  end
  // Reference counter, advanced at each tick and fed from the SFR writes it sees
  always @(posedge clk_sys) begin
    if (!arst_n) begin
      modelCount = 0;
      sinceTick = -1;
      loadPending = 0;
      ctrlStrobe = 0;
      ctrlLoad = 0;
      checkCount = 0;
    end else begin
      sinceTick++;
      // The count taken at a tick is visible one edge later
      if (checkCount) chk(quarterCount, modelCount);
      checkCount = quarterTick;
      if (quarterTick) begin
        chk(sinceTick, TickDiv);
        sinceTick = 0;
        modelCount = loadPending ? loadValue : (modelCount == 239 ? 0 : modelCount + 1);
        loadPending = 0;
      end
      if (sfrLink.sfrWrEn && sfrLink.sfrAddr == 8'hce) loadValue = sfrLink.sfrWrData;
      if (sfrLink.sfrWrEn && sfrLink.sfrAddr == 8'hcd) begin
        // The strobe edge uses the load bit stored by the earlier control write
        if (sfrLink.sfrWrData[0] && !ctrlStrobe && ctrlLoad) loadPending = 1;
        ctrlStrobe = sfrLink.sfrWrData[0];
        ctrlLoad = sfrLink.sfrWrData[1];
      end
    end
  end
  task automatic apb(input bit wr, input logic [11:0] addr, input logic [31:0] data,
      output logic [31:0] rdata, output logic err);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) begin
      @(posedge clk_sys);
    end
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic sfr(input bit wr, input logic [7:0] addr, input logic [7:0] data,
      output logic [7:0] rdata);
    logic [31:0] st;
    logic e;
    apb(1'b1, `MTK_HOST_CMD_OFFSET, {14'h0, 1'b1, wr, addr, data}, st, e);
    st = 32'h1;
    while (st[`MTK_STAT_BUSY_BIT] !== 1'b0) begin
      apb(1'b0, `MTK_HOST_STATUS_OFFSET, 32'h0, st, e);
    end
    rdata = st[`MTK_STAT_RDATA_LSB +: 8];
  endtask
  task automatic waitTick(input int k);
    repeat (k) begin
      @(posedge clk_sys);
      while (quarterTick !== 1'b1) @(posedge clk_sys);
    end
    // One more edge so that what the tick launched has settled
    @(posedge clk_sys);
  endtask
  task automatic timeSet(input logic [7:0] v);
    logic [7:0] b;
    sfr(1'b1, 8'hcd, 8'h06, b);
    sfr(1'b1, 8'hce, v, b);
    sfr(1'b1, 8'hcd, 8'h07, b);
  endtask
  initial begin
    logic [7:0] b;
    logic [7:0] held;
    logic e;
    repeat (16) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    apb(1'b0, `MTK_HOST_IRQ_MASK_OFFSET, 32'h0, rd, e);
    chk(rd, 32'h0);
    apb(1'b0, 12'h010, 32'h0, rd, e);
    chk(e, 1'b1);
    sfr(1'b0, 8'h90, 8'h00, b);
    chk(b, 8'h00);
    apb(1'b1, `MTK_HOST_IRQ_MASK_OFFSET, 32'h1, rd, e);
    sfr(1'b1, 8'hcd, 8'h06, b);
    sfr(1'b1, 8'hce, 8'h55, b);
    waitTick(2);
    sfr(1'b0, 8'hce, 8'h00, b);
    chk(b, 8'h55);
    sfr(1'b0, 8'hcd, 8'h00, b);
    chk(b[2], 1'b1);
    sfr(1'b1, 8'hcd, 8'h07, b);
    waitTick(1);
    sfr(1'b0, 8'hcd, 8'h00, b);
    chk(b[2], 1'b0);
    sfr(1'b0, 8'hce, 8'h00, b);
    chk(b, modelCount);
    timeSet(8'hee);
    waitTick(2);
    chk(sfrLink.minuteIrq, 1'b1);
    apb(1'b0, `MTK_HOST_IRQ_STATUS_OFFSET, 32'h0, rd, e);
    chk(rd[0], 1'b1);
    chk(irqOut, 1'b1);
    waitTick(1);
    sfr(1'b1, 8'hcd, 8'h00, b);
    sfr(1'b1, 8'hcd, 8'h01, b);
    chk(sfrLink.minuteIrq, 1'b0);
    sfr(1'b1, 8'hcd, 8'h80, b);
    sfr(1'b1, 8'hcd, 8'h81, b);
    chk(sfrLink.minuteIrq, 1'b1);
    sfr(1'b1, 8'hcd, 8'h00, b);
    sfr(1'b1, 8'hcd, 8'h01, b);
    apb(1'b1, `MTK_HOST_IRQ_STATUS_OFFSET, 32'h3, rd, e);
    apb(1'b0, `MTK_HOST_IRQ_STATUS_OFFSET, 32'h0, rd, e);
    chk(rd[0], 1'b0);
    chk(irqOut, 1'b0);
    // Supply drop: counting and minute go on, the register freezes
    waitTick(1);
    supplyStablePin <= 1'b0;
    converterActivePin <= 1'b0;
    held = modelCount;
    waitTick(3);
    sfr(1'b0, 8'hce, 8'h00, b);
    chk(b, held);
    timeSet(8'hee);
    waitTick(2);
    sfr(1'b0, 8'hcd, 8'h00, b);
    chk(b[7], 1'b1);
    chk(converterStart, 1'b1);
    converterActivePin <= 1'b1;
    supplyStablePin <= 1'b1;
    sfr(1'b1, 8'hcd, 8'h00, b);
    sfr(1'b1, 8'hcd, 8'h01, b);
    chk(converterStart, 1'b0);
    repeat (3) begin
      timeSet(8'($unsigned($random(seed)) % 239));
      waitTick(2);
      sfr(1'b0, 8'hce, 8'h00, b);
      chk(b, modelCount);
    end
    arst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b1;
    waitTick(2);
    finishTest();
  end
endmodule
